// ===== async_serial_receiver_mode0_bench.sv
`timescale 1ns/100ps
module async_serial_receiver_mode0_bench;
  logic mclk, rst, serial, even, pdis, hi, lo, srel, brel, clr_n, wr, rd;
  logic [1:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] bus;
  logic bus_oe, rdy, ovr, par, frm, st_oe, irq;
  int fails = 0;
  int total_checks = 0;

  rxm_tx_model i_tx (.mclk_i(mclk), .line_o(serial));
  rxm_receiver i_dut (.mclk_i(mclk), .reset_i(rst), .serial_rx_in_i(serial),
    .even_parity_select_i(even), .parity_disable_i(pdis), .char_len_sel_hi_i(hi),
    .char_len_sel_lo_i(lo), .status_output_release_i(srel), .rx_bus_release_i(brel),
    .ready_flag_clear_n_i(clr_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_bus_o(bus), .rx_bus_oe_o(bus_oe),
    .rx_char_ready_flag_o(rdy), .overrun_flag_o(ovr), .parity_mismatch_flag_o(par),
    .stop_bit_missing_flag_o(frm), .status_oe_o(st_oe), .irq_o(irq));

  // Free-running 25 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_reg(input logic [1:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask : rd_reg

  // Format pins are set one edge ahead, since they are captured at the start edge.
  task automatic rx_char(input logic [7:0] d, input logic [1:0] len, input logic pd,
      input logic ev, input logic bp, input logic bs);
    int i;
    @(posedge mclk);
    {even, pdis, hi, lo} <= {ev, pd, len};
    i_tx.send(d, len, pd, ev, bp, bs);
    for (i = 0; i < 400 && rdy !== 1'b1; i++) @(posedge mclk);
    if (rdy !== 1'b1)
    begin
      $display("CHECK FAILED ready expected 1 seen %b", rdy);
      fails++;
      end_of_test();
    end
  endtask : rx_char

  task automatic clear_ready;
    @(posedge mclk);
    clr_n <= 1'b0;
    @(posedge mclk);
    clr_n <= 1'b1;
    @(posedge mclk);
    #1 chk("ready", 32'h0, {31'h0, rdy});
  endtask : clear_ready

  // Main sequence.
  initial
  begin
    {rst, even, pdis, hi, lo, srel, brel, wr, rd} = 9'h100;
    clr_n = 1'b1;
    addr = 2'h0;
    wdata = 32'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(2'h1, 32'h0, "mask reset");
    wr_reg(2'h3, 32'hf);
    rd_reg(2'h3, 32'h0, "unmapped");
    wr_reg(2'h0, 32'hf);
    wr_reg(2'h1, 32'h1);
    rd_reg(2'h0, 32'h0, "status reset");
    chk("irq idle", 32'h0, {31'h0, irq});
    rx_char(8'ha5, 2'h3, 1'b0, 1'b1, 1'b0, 1'b0);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rd_reg(2'h2, 32'h8a5, "state");
    rd_reg(2'h0, 32'h1, "status");
    wr_reg(2'h0, 32'h1);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    wr_reg(2'h1, 32'h0);
    clear_ready();
    for (int i = 0; i < 8; i++)
    begin
      rx_char(8'(8'hf0 ^ (i * 8'h1d)), i[1:0], 1'b0, i[2], i[0], 1'b0);
      chk("data", (8'hf0 ^ (i * 8'h1d)) & (8'hff >> (2'd3 - i[1:0])), bus);
      chk("parity", i[0], par);
      chk("framing", 32'h0, frm);
      chk("overrun", 32'h0, ovr);
      clear_ready();
    end
    rx_char(8'h3c, 2'h3, 1'b1, 1'b0, 1'b1, 1'b1);
    chk("no parity", 32'h0, par);
    chk("bad stop", 32'h1, frm);
    rx_char(8'h81, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("overrun set", 32'h1, ovr);
    chk("data", 32'h81, bus);
    // Every event kind has now happened at least once since the status was last cleared.
    rd_reg(2'h0, 32'hf, "status events");
    clear_ready();
    i_tx.glitch(7);
    repeat (200) @(posedge mclk);
    chk("false start", 32'h0, {31'h0, rdy});
    rx_char(8'h5a, 2'h3, 1'b0, 1'b1, 1'b0, 1'b0);
    chk("after false", 32'h5a, bus);
    @(posedge mclk);
    {srel, brel} <= 2'b11;
    @(posedge mclk);
    #1 chk("oe off", 32'h0, {bus_oe, st_oe});
    @(posedge mclk);
    {srel, brel} <= 2'b00;
    @(posedge mclk);
    #1 chk("oe on", 32'h3, {bus_oe, st_oe});
    end_of_test();
  end
endmodule : async_serial_receiver_mode0_bench

// ===== rxm_cell_counter.sv
`timescale 1ns/100ps
module rxm_cell_counter #(
  parameter int unsigned CNT_W = rxm_pkg::CELL_W
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic restart_i,
  input wire logic run_i,
  output logic mid_cell_o
);

  logic [CNT_W-1:0] count_r;

  // The cycle that sees the edge counts as zero, so the restart loads one.
  // The counter wraps at sixteen, giving one mid-cell tick per bit time.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      count_r <= CNT_W'(rxm_pkg::CELL_ZERO);
    end
    else if (restart_i)
    begin
      count_r <= CNT_W'(rxm_pkg::CELL_RESTART);
    end
    else if (run_i)
    begin
      count_r <= count_r + CNT_W'(1);
    end
  end

  // Mid-cell strobe, used for start verification and every bit sample.
  assign mid_cell_o = run_i && (count_r == CNT_W'(rxm_pkg::SAMPLE_POINT));

endmodule : rxm_cell_counter

// ===== rxm_checker.sv
`timescale 1ns/100ps
module rxm_checker #(
  parameter int unsigned DATA_W = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic serial_rx_in_i,
  input wire logic status_output_release_i,
  input wire logic rx_bus_release_i,
  input wire logic ready_flag_clear_n_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [DATA_W-1:0] rx_bus_o,
  input wire logic rx_bus_oe_o,
  input wire logic rx_char_ready_flag_o,
  input wire logic overrun_flag_o,
  input wire logic stop_bit_missing_flag_o,
  input wire logic status_oe_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  // A fresh holding value must be followed by ready on the next edge.
  sequence s_load;
    $changed(rx_bus_o);
  endsequence
  sequence s_ready_next;
    ##1 rx_char_ready_flag_o;
  endsequence

  a_hold_then_ready: assert property (s_load |-> s_ready_next)
    else $error("ready did not follow a holding load");
  a_stop_frame_flag: assert property ($rose(rx_char_ready_flag_o) |->
    stop_bit_missing_flag_o == !$past(serial_rx_in_i, 2))
    else $error("framing flag disagrees with sampled stop bit");
  a_overrun_cause: assert property ($rose(rx_char_ready_flag_o) |->
    overrun_flag_o == $past(rx_char_ready_flag_o, 2))
    else $error("overrun flag disagrees with ready at load");
  a_ready_clear: assert property ($fell(rx_char_ready_flag_o) |->
    !$past(ready_flag_clear_n_i))
    else $error("ready dropped without a clear pulse");
  a_ready_holds: assert property (rx_char_ready_flag_o && ready_flag_clear_n_i |=>
    rx_char_ready_flag_o)
    else $error("ready dropped while clear was high");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data not zero outside the answer cycle");
  a_status_drive: assert property (status_oe_o == !status_output_release_i)
    else $error("status drive enable wrong");
  a_bus_drive: assert property (rx_bus_oe_o == !rx_bus_release_i)
    else $error("receive bus drive enable wrong");
endmodule : rxm_checker

bind rxm_receiver rxm_checker #(.DATA_W(DATA_W)) i_chk (
  .mclk_i(mclk_i),
  .reset_i(reset_i),
  .serial_rx_in_i(serial_rx_in_i),
  .status_output_release_i(status_output_release_i),
  .rx_bus_release_i(rx_bus_release_i),
  .ready_flag_clear_n_i(ready_flag_clear_n_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .rx_bus_o(rx_bus_o),
  .rx_bus_oe_o(rx_bus_oe_o),
  .rx_char_ready_flag_o(rx_char_ready_flag_o),
  .overrun_flag_o(overrun_flag_o),
  .stop_bit_missing_flag_o(stop_bit_missing_flag_o),
  .status_oe_o(status_oe_o)
);

// ===== rxm_pkg.sv
package rxm_pkg;

  // Divide ratio of the bit cell and the mid-cell sample point.
  localparam int unsigned CELL_DIV = 16;
  localparam int unsigned CELL_W = 4;
  localparam logic [3:0] SAMPLE_POINT = 4'h7;
  localparam logic [3:0] CELL_RESTART = 4'h1;
  localparam logic [3:0] CELL_ZERO = 4'h0;

  // Character length limits.
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] MIN_CHAR_BITS = 4'h5;

  // Cycles from holding register load until the parity and framing flags and ready are valid; overrun is loaded with the holding register.
  localparam int unsigned FLAG_DELAY_CYC = 1;

  // Register map of the software port, word indices.
  localparam int unsigned ADDR_W = 2;
  localparam logic [1:0] REG_IRQ_STATUS = 2'h0;
  localparam logic [1:0] REG_IRQ_MASK = 2'h1;
  localparam logic [1:0] REG_RX_STATE = 2'h2;

  // Bit positions of the interrupt events.
  localparam int unsigned EV_CHAR = 0;
  localparam int unsigned EV_OVERRUN = 1;
  localparam int unsigned EV_PARITY = 2;
  localparam int unsigned EV_FRAMING = 3;
  localparam int unsigned EV_W = 4;

  // Reset values.
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam logic [7:0] HOLD_RST = 8'h00;

  typedef enum logic [2:0] {
    RXM_IDLE,
    RXM_START,
    RXM_DATA,
    RXM_PARITY,
    RXM_STOP
  } rxm_state_t;

  // Character format as taken from the select pins.
  typedef struct packed {
    logic even_parity_select;
    logic parity_disable;
    logic char_len_sel_hi;
    logic char_len_sel_lo;
  } rxm_cfg_t;

  // Receiver status flags.
  typedef struct packed {
    logic rx_char_ready_flag;
    logic overrun_flag;
    logic parity_mismatch_flag;
    logic stop_bit_missing_flag;
  } rxm_flags_t;

  // Number of data bits selected by the two length pins.
  function automatic logic [3:0] rxm_char_bits(input rxm_cfg_t cfg);
    rxm_char_bits = MIN_CHAR_BITS + {2'b00, cfg.char_len_sel_hi, cfg.char_len_sel_lo};
  endfunction : rxm_char_bits

endpackage : rxm_pkg

// ===== rxm_receiver.sv
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module rxm_receiver #(
  parameter int unsigned DATA_W = rxm_pkg::DATA_W
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic serial_rx_in_i,
  input wire logic even_parity_select_i,
  input wire logic parity_disable_i,
  input wire logic char_len_sel_hi_i,
  input wire logic char_len_sel_lo_i,
  input wire logic status_output_release_i,
  input wire logic rx_bus_release_i,
  input wire logic ready_flag_clear_n_i,
  input wire logic [rxm_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [DATA_W-1:0] rx_bus_o,
  output logic rx_bus_oe_o,
  output logic rx_char_ready_flag_o,
  output logic overrun_flag_o,
  output logic parity_mismatch_flag_o,
  output logic stop_bit_missing_flag_o,
  output logic status_oe_o,
  output logic irq_o
);

  rxm_pkg::rxm_state_t state_r;
  rxm_pkg::rxm_state_t state_nxt;
  rxm_pkg::rxm_cfg_t cfg_r;
  rxm_pkg::rxm_cfg_t cfg_pins;
  rxm_pkg::rxm_flags_t flags_r;
  logic rx_prev_r;
  logic falling_edge;
  logic mid_cell;
  logic cell_restart;
  logic cell_run;
  logic [3:0] bit_idx_r;
  logic [3:0] char_bits;
  logic [DATA_W-1:0] shift_r;
  logic [DATA_W-1:0] hold_r;
  logic parity_bit_r;
  logic load_hold;
  logic load_d_r;
  logic parity_err_d_r;
  logic framing_err_d_r;
  logic parity_err_now;
  logic ready_clear;
  logic [rxm_pkg::EV_W-1:0] irq_status_r;
  logic [rxm_pkg::EV_W-1:0] irq_mask_r;
  logic [rxm_pkg::EV_W-1:0] irq_events;
  logic [31:0] rdata_r;

  assign cfg_pins = '{even_parity_select: even_parity_select_i,
                      parity_disable: parity_disable_i,
                      char_len_sel_hi: char_len_sel_hi_i,
                      char_len_sel_lo: char_len_sel_lo_i};
  assign char_bits = rxm_pkg::rxm_char_bits(cfg_r);
  assign ready_clear = !ready_flag_clear_n_i;

  // Remember the line level so a high-to-low step can be seen.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      rx_prev_r <= 1'b1;
    end
    else
    begin
      rx_prev_r <= serial_rx_in_i;
    end
  end

  // Only an edge seen while idle opens a character.
  assign falling_edge = (state_r == rxm_pkg::RXM_IDLE) && rx_prev_r && !serial_rx_in_i;
  assign cell_restart = falling_edge;
  assign cell_run = (state_r != rxm_pkg::RXM_IDLE);

  rxm_cell_counter #(
    .CNT_W(rxm_pkg::CELL_W)
  ) u_cell (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .restart_i(cell_restart),
    .run_i(cell_run),
    .mid_cell_o(mid_cell)
  );

  // Sequencing of the character frame, one step per mid-cell tick.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      rxm_pkg::RXM_IDLE:
      begin
        if (falling_edge)
        begin
          state_nxt = rxm_pkg::RXM_START;
        end
      end
      rxm_pkg::RXM_START:
      begin
        if (mid_cell)
        begin
          // A glitch shorter than half a bit is thrown away here.
          state_nxt = serial_rx_in_i ? rxm_pkg::RXM_IDLE : rxm_pkg::RXM_DATA;
        end
      end
      rxm_pkg::RXM_DATA:
      begin
        if (mid_cell && (bit_idx_r == char_bits - 4'h1))
        begin
          state_nxt = cfg_r.parity_disable ? rxm_pkg::RXM_STOP : rxm_pkg::RXM_PARITY;
        end
      end
      rxm_pkg::RXM_PARITY:
      begin
        if (mid_cell)
        begin
          state_nxt = rxm_pkg::RXM_STOP;
        end
      end
      rxm_pkg::RXM_STOP:
      begin
        // Going idle at mid stop lets the next start edge be caught early.
        if (mid_cell)
        begin
          state_nxt = rxm_pkg::RXM_IDLE;
        end
      end
      default:
      begin
        state_nxt = rxm_pkg::RXM_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_r <= rxm_pkg::RXM_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Format is captured at the start edge so pin changes mid-frame cannot
  // split a character between two formats.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      cfg_r <= '0;
    end
    else if (falling_edge)
    begin
      cfg_r <= cfg_pins;
    end
  end

  // Data bits land by index; clearing at the edge leaves upper bits zero.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      shift_r <= '0;
      bit_idx_r <= 4'h0;
      parity_bit_r <= 1'b0;
    end
    else if (falling_edge)
    begin
      shift_r <= '0;
      bit_idx_r <= 4'h0;
    end
    else if (mid_cell && (state_r == rxm_pkg::RXM_DATA))
    begin
      shift_r[bit_idx_r[2:0]] <= serial_rx_in_i;
      bit_idx_r <= bit_idx_r + 4'h1;
    end
    else if (mid_cell && (state_r == rxm_pkg::RXM_PARITY))
    begin
      parity_bit_r <= serial_rx_in_i;
    end
  end

  // Load happens at mid-cell of the first stop bit.
  assign load_hold = mid_cell && (state_r == rxm_pkg::RXM_STOP);

  // Odd parity wants an odd count of ones across data and parity bit.
  assign parity_err_now = !cfg_r.parity_disable &&
    ((^shift_r ^ parity_bit_r) != !cfg_r.even_parity_select);

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      hold_r <= rxm_pkg::HOLD_RST;
    end
    else if (load_hold)
    begin
      hold_r <= shift_r;
    end
  end

  // Error results wait one cycle, the synchronous stand-in for half a clock.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      load_d_r <= 1'b0;
      parity_err_d_r <= 1'b0;
      framing_err_d_r <= 1'b0;
    end
    else
    begin
      load_d_r <= load_hold;
      if (load_hold)
      begin
        parity_err_d_r <= parity_err_now;
        framing_err_d_r <= !serial_rx_in_i;
      end
    end
  end

  // Overrun follows the load; ready follows one cycle later and wins a clear.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      flags_r <= '0;
    end
    else
    begin
      if (load_hold)
      begin
        flags_r.overrun_flag <= flags_r.rx_char_ready_flag;
      end
      if (load_d_r)
      begin
        flags_r.parity_mismatch_flag <= parity_err_d_r;
        flags_r.stop_bit_missing_flag <= framing_err_d_r;
        flags_r.rx_char_ready_flag <= 1'b1;
      end
      else if (ready_clear)
      begin
        flags_r.rx_char_ready_flag <= 1'b0;
      end
    end
  end

  // Pin outputs always carry register values; enables decide who drives.
  assign rx_bus_o = hold_r;
  assign rx_bus_oe_o = !rx_bus_release_i;
  assign rx_char_ready_flag_o = flags_r.rx_char_ready_flag;
  assign overrun_flag_o = flags_r.overrun_flag;
  assign parity_mismatch_flag_o = flags_r.parity_mismatch_flag;
  assign stop_bit_missing_flag_o = flags_r.stop_bit_missing_flag;
  assign status_oe_o = !status_output_release_i;

  // Events that feed the sticky interrupt status, all at flag-valid time.
  always_comb
  begin
    irq_events = '0;
    irq_events[rxm_pkg::EV_CHAR] = load_d_r;
    irq_events[rxm_pkg::EV_OVERRUN] = load_d_r && flags_r.overrun_flag;
    irq_events[rxm_pkg::EV_PARITY] = load_d_r && parity_err_d_r;
    irq_events[rxm_pkg::EV_FRAMING] = load_d_r && framing_err_d_r;
  end

  // Write-one-to-clear status; a new event in the same cycle stays set.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      irq_status_r <= '0;
    end
    else if (reg_wr_i && (reg_addr_i == rxm_pkg::REG_IRQ_STATUS))
    begin
      irq_status_r <= (irq_status_r & ~reg_wdata_i[rxm_pkg::EV_W-1:0]) | irq_events;
    end
    else
    begin
      irq_status_r <= irq_status_r | irq_events;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      irq_mask_r <= rxm_pkg::IRQ_MASK_RST;
    end
    else if (reg_wr_i && (reg_addr_i == rxm_pkg::REG_IRQ_MASK))
    begin
      irq_mask_r <= reg_wdata_i[rxm_pkg::EV_W-1:0];
    end
  end

  assign irq_o = |(irq_status_r & irq_mask_r);

  // Read data stand only in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      rdata_r <= '0;
    end
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        rxm_pkg::REG_IRQ_STATUS: rdata_r <= {28'h0000000, irq_status_r};
        rxm_pkg::REG_IRQ_MASK: rdata_r <= {28'h0000000, irq_mask_r};
        rxm_pkg::REG_RX_STATE: rdata_r <= {16'h0000, state_r, 1'b0, flags_r, hold_r};
        default: rdata_r <= '0;
      endcase
    end
    else
    begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule : rxm_receiver

// ===== rxm_tx_model.sv
`timescale 1ns/100ps
module rxm_tx_model (
  input wire logic mclk_i,
  output logic line_o
);
  // The line idles high between characters.
  initial line_o = 1'b1;

  // One character, LSB first, 16 clocks a bit, optional parity, one stop bit.
  task automatic send(input logic [7:0] d, input logic [1:0] len, input logic pdis,
      input logic even, input logic bad_par, input logic bad_stop);
    logic [10:0] fr;
    int n;
    int p;
    n = 5 + len;
    p = pdis ? 0 : 1;
    fr = {3'h7, d, 1'b0};
    for (int k = n + 1; k < 11; k++) fr[k] = 1'b1;
    if (p == 1) fr[n + 1] = ^(d & (8'hff >> (8 - n))) ^ !even ^ bad_par;
    fr[n + 1 + p] = !bad_stop;
    for (int k = 0; k < n + 2 + p; k++)
    begin
      @(posedge mclk_i);
      line_o <= fr[k];
      repeat (15) @(posedge mclk_i);
    end
    @(posedge mclk_i);
    line_o <= 1'b1;
  endtask : send

  // A low pulse of n clocks, too short to pass start qualification when n is 7.
  task automatic glitch(input int n);
    @(posedge mclk_i);
    line_o <= 1'b0;
    repeat (n) @(posedge mclk_i);
    line_o <= 1'b1;
  endtask : glitch
endmodule : rxm_tx_model
